// ### common/rtfc_cfg.svh
// Register offsets, field positions and reset values of the FIFO control bank
`ifndef RTFC_CFG_SVH
`define RTFC_CFG_SVH

// ============================================================
// Register byte addresses
`define RTFC_RXCFG_ADDR      8'h6C
`define RTFC_TXCFG_ADDR      8'h70
`define RTFC_STAT_ADDR       8'h78
`define RTFC_ADDR_W          8

// ============================================================
// Receive configuration fields
`define RTFC_RX_ALIGN_HI     31
`define RTFC_RX_ALIGN_LO     30
`define RTFC_RX_DISCARD_BIT  15
`define RTFC_RX_OFF_HI       12
`define RTFC_RX_OFF_LO       8
`define RTFC_RX_OFF_DW_LO    10
`define RTFC_RX_OFF_BYTE_HI  9

// ============================================================
// Transmit configuration fields
`define RTFC_TXS_DISCARD_BIT 15
`define RTFC_TXD_DISCARD_BIT 14
`define RTFC_TX_PERMIT_BIT   2
`define RTFC_TX_ENABLE_BIT   1
`define RTFC_TX_STOP_BIT     0

// ============================================================
// Status register fields
`define RTFC_ST_TX_ACTIVE    0
`define RTFC_ST_TX_SUSPEND   1
`define RTFC_ST_TSF_FULL     2
`define RTFC_ST_STOPPING     3

// ============================================================
// Reset values and encodings
`define RTFC_ALIGN_RST       2'h0
`define RTFC_ALIGN_4         2'h0
`define RTFC_ALIGN_16        2'h1
`define RTFC_ALIGN_32        2'h2
`define RTFC_ALIGN_RSVD      2'h3
`define RTFC_OFF_RST         5'h00
`define RTFC_RESP_OKAY       2'h0
`define RTFC_RESP_SLVERR     2'h2
`define RTFC_FILL_4          3'h0
`define RTFC_FILL_16         3'h3
`define RTFC_FILL_32         3'h7
`define RTFC_ZERO32          32'h0000_0000

`endif

// ### common/rtfc_pkg.sv
// Types shared by the FIFO control bank
package rtfc_pkg;
  typedef enum logic [1:0] {
    RTFC_TX_IDLE,
    RTFC_TX_RUN,
    RTFC_TX_DRAIN
  } rtfc_tx_state_t;

  typedef logic [1:0] rtfc_align_t;
  typedef logic [4:0] rtfc_offset_t;
endpackage

// ### hdl/rtfc_tx_ctrl.sv
// Transmitter enable and stop handshake
`timescale 1ns/1ps
`include "rtfc_cfg.svh"
module rtfc_tx_ctrl
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic enable_set,
  input  wire logic enable_clr,
  input  wire logic stop_req,
  input  wire logic overrun_permit,
  input  wire logic status_full,
  input  wire logic frame_avail,
  input  wire logic frame_done,
  output logic      enable,
  output logic      stopping,
  output logic      frame_start,
  output logic      active,
  output logic      suspended
);
  import rtfc_pkg::*;
  typedef struct packed {
    rtfc_tx_state_t st;
    logic           en;
    logic           stop;
  } rtfc_txc_t;

  rtfc_txc_t s_q;
  rtfc_txc_t s_d;
  logic      hold;

  // ============================================================
  // Next state
  always_comb begin
    s_d  = s_q;
    hold = status_full && !overrun_permit;
    if (enable_set) begin
      s_d.en = 1'b1;
    end
    if (enable_clr) begin
      s_d.en = 1'b0;
    end
    // Stop writes while a stop is pending are dropped
    if (stop_req && !s_q.stop) begin
      s_d.stop = 1'b1;
    end
    case (s_q.st)
      RTFC_TX_IDLE: begin
        if (s_q.stop) begin
          s_d.stop = 1'b0;
          s_d.en   = 1'b0;
        end else if (s_q.en && frame_avail && !hold) begin
          s_d.st = RTFC_TX_RUN;
        end
      end
      RTFC_TX_RUN: begin
        if (frame_done) begin
          s_d.st = RTFC_TX_DRAIN;
        end
      end
      RTFC_TX_DRAIN: begin
        s_d.st = RTFC_TX_IDLE;
      end
      default: begin
        s_d.st = RTFC_TX_IDLE;
      end
    endcase
    if (!aresetn) begin
      s_d = '{st: RTFC_TX_IDLE, en: 1'b0, stop: 1'b0};
    end
  end

  always_ff @(posedge aclk) begin
    s_q <= s_d;
  end

  assign enable      = s_q.en;
  assign stopping    = s_q.stop;
  assign active      = (s_q.st != RTFC_TX_IDLE);
  assign suspended   = hold;
  assign frame_start = (s_q.st == RTFC_TX_IDLE) && s_d.st == RTFC_TX_RUN;

  // ============================================================
  // Checks
  a_frame_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_start |-> s_q.en && !s_q.stop && (overrun_permit || !status_full))
    else $error("frame started while gated");
  a_stop_finish: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.stop && s_q.st == RTFC_TX_IDLE) |=> !s_q.stop && !s_q.en)
    else $error("stop not completed when idle");
  a_stop_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.stop && s_q.st != RTFC_TX_IDLE) |=> s_q.stop)
    else $error("pending stop lost mid frame");
  c_stop_mid_frame: cover property (@(posedge aclk) disable iff (!aresetn)
    s_q.stop && s_q.st == RTFC_TX_RUN);
  c_suspend: cover property (@(posedge aclk) disable iff (!aresetn)
    s_q.en && frame_avail && hold);
endmodule

// ### hdl/rtfc_rx_align.sv
// Receive offset staging and end-alignment filler count
`timescale 1ns/1ps
`include "rtfc_cfg.svh"
module rtfc_rx_align
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire rtfc_pkg::rtfc_offset_t offset_reg,
  input  wire rtfc_pkg::rtfc_align_t  align_reg,
  input  wire logic                   dword_read,
  input  wire logic [2:0]             dword_pos,
  input  wire logic                   last_dword,
  output rtfc_pkg::rtfc_offset_t      offset_live,
  output logic [2:0]                  fill_count,
  output logic                        align_bad
);
  import rtfc_pkg::*;
  typedef struct packed {
    logic [2:0] dw_off;
  } rtfc_rxa_t;

  rtfc_rxa_t  s_q;
  rtfc_rxa_t  s_d;
  logic [2:0] mask;

  // ============================================================
  // Offset staging: upper bits move only at a DWORD read boundary
  always_comb begin
    s_d = s_q;
    if (dword_read) begin
      s_d.dw_off = offset_reg[`RTFC_RX_OFF_HI-`RTFC_RX_OFF_LO:`RTFC_RX_OFF_DW_LO-`RTFC_RX_OFF_LO];
    end
    if (!aresetn) begin
      s_d.dw_off = 3'h0;
    end
  end

  always_ff @(posedge aclk) begin
    s_q <= s_d;
  end

  // Byte bits are applied directly; software keeps them steady while running
  assign offset_live = {s_q.dw_off, offset_reg[`RTFC_RX_OFF_BYTE_HI-`RTFC_RX_OFF_LO:0]};

  always_comb begin
    case (align_reg)
      `RTFC_ALIGN_4:  mask = `RTFC_FILL_4;
      `RTFC_ALIGN_16: mask = `RTFC_FILL_16;
      `RTFC_ALIGN_32: mask = `RTFC_FILL_32;
      default:        mask = `RTFC_FILL_4;
    endcase
  end

  // Filler DWORDs after the last transfer up to the boundary
  assign fill_count = last_dword ? (mask & (3'h0 - dword_pos - 3'h1)) : 3'h0;
  assign align_bad  = (align_reg == `RTFC_ALIGN_RSVD);

  a_fill_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    last_dword |-> ((fill_count & ~mask) == 3'h0) && (((dword_pos + fill_count + 3'h1) & mask) == 3'h0))
    else $error("filler count misaligned");
  a_offset_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !dword_read |=> $stable(s_q.dw_off))
    else $error("dword offset changed without read");
  a_align_legal: assert property (@(posedge aclk) disable iff (!aresetn)
    !align_bad)
    else $error("reserved alignment code applied");
  c_align32: cover property (@(posedge aclk) disable iff (!aresetn)
    last_dword && align_reg == `RTFC_ALIGN_32 && fill_count != 3'h0);
endmodule

// ### hdl/rtfc_top.sv
// AXI4-Lite register bank for receive and transmit FIFO control
`timescale 1ns/1ps
`include "rtfc_cfg.svh"
// Contract
// - Receive discard clears RX pointers, self-clears
// - Five-bit offset shifts delivered packet start
// - Offset DWORD bits apply at next read
// - Alignment codes 4, 16, 32 bytes, reserved
// - Filler DWORDs pad to end alignment
// - Status discard clears TX status pointers
// - Data discard clears TX data pointers
// - Full status FIFO suspends unless permitted
// - Status full flag independent of permit
// - Enable set sends queued frames
// - Hardware clears enable after stop halts
// - Stop finishes frame, then clears itself
// - Stop writes ignored while stop pending
module rtfc_top
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [`RTFC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [`RTFC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    rx_dword_read,
  input  wire logic [2:0]              rx_dword_pos,
  input  wire logic                    rx_last_dword,
  input  wire logic                    tx_status_full,
  input  wire logic                    tx_frame_avail,
  input  wire logic                    tx_frame_done,
  output logic                         rx_fifo_ptr_clear,
  output logic                         tx_status_ptr_clear,
  output logic                         tx_data_ptr_clear,
  output logic [4:0]                   rx_start_byte_offset,
  output logic [2:0]                   rx_fill_dwords,
  output logic                         tx_frame_start,
  output logic                         tx_running,
  output logic                         tx_status_full_flag
);
  import rtfc_pkg::*;
  typedef struct packed {
    logic                    aw_full;
    logic [`RTFC_ADDR_W-1:0] aw_addr;
    logic                    w_full;
    logic [31:0]             w_data;
    logic [3:0]              w_strb;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
    rtfc_align_t             align;
    rtfc_offset_t            offset;
    logic                    permit;
    logic                    rx_clr;
    logic                    txs_clr;
    logic                    txd_clr;
    logic [4:0]              off_out;
    logic [2:0]              fill_out;
    logic                    start_out;
    logic                    run_out;
    logic                    full_out;
    logic                    aw_rdy;
    logic                    w_rdy;
    logic                    ar_rdy;
  } rtfc_top_st_t;

  rtfc_top_st_t s_q;
  rtfc_top_st_t s_d;

  logic         wr_go;
  logic [31:0]  wv;
  logic         en_set;
  logic         en_clr;
  logic         stop_wr;
  logic         tx_en;
  logic         tx_stopping;
  logic         tx_active;
  logic         tx_susp;
  logic         tx_start;
  rtfc_offset_t off_live;
  logic [2:0]   fill_cnt;
  logic         align_bad;
  logic [31:0]  rx_word;
  logic [31:0]  tx_word;
  logic [31:0]  st_word;

  // ============================================================
  // Register images; reserved and discard bits read zero
  always_comb begin
    rx_word = `RTFC_ZERO32;
    rx_word[`RTFC_RX_ALIGN_HI:`RTFC_RX_ALIGN_LO] = s_q.align;
    rx_word[`RTFC_RX_OFF_HI:`RTFC_RX_OFF_LO]     = s_q.offset;
    tx_word = `RTFC_ZERO32;
    tx_word[`RTFC_TX_PERMIT_BIT] = s_q.permit;
    tx_word[`RTFC_TX_ENABLE_BIT] = tx_en;
    tx_word[`RTFC_TX_STOP_BIT]   = tx_stopping;
    st_word = `RTFC_ZERO32;
    st_word[`RTFC_ST_TX_ACTIVE]  = tx_active;
    st_word[`RTFC_ST_TX_SUSPEND] = tx_susp;
    st_word[`RTFC_ST_TSF_FULL]   = tx_status_full;
    st_word[`RTFC_ST_STOPPING]   = tx_stopping;
  end

  // Write data merged with current image under byte strobes
  always_comb begin
    wv = (s_q.aw_addr == `RTFC_RXCFG_ADDR) ? rx_word : tx_word;
    for (int i = 0; i < 4; i++) begin
      if (s_q.w_strb[i]) begin
        wv[i*8 +: 8] = s_q.w_data[i*8 +: 8];
      end
    end
  end

  assign wr_go   = s_q.aw_full && s_q.w_full && !s_q.bvalid;
  assign en_set  = wr_go && s_q.aw_addr == `RTFC_TXCFG_ADDR && s_q.w_strb[0] && wv[`RTFC_TX_ENABLE_BIT];
  assign en_clr  = wr_go && s_q.aw_addr == `RTFC_TXCFG_ADDR && s_q.w_strb[0] && !wv[`RTFC_TX_ENABLE_BIT];
  assign stop_wr = wr_go && s_q.aw_addr == `RTFC_TXCFG_ADDR && s_q.w_strb[0] && wv[`RTFC_TX_STOP_BIT];

  // ============================================================
  // Bus slave and configuration state
  always_comb begin
    s_d         = s_q;
    s_d.rx_clr  = 1'b0;
    s_d.txs_clr = 1'b0;
    s_d.txd_clr = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_full = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_full = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (wr_go) begin
      s_d.aw_full = 1'b0;
      s_d.w_full  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = `RTFC_RESP_OKAY;
      case (s_q.aw_addr)
        `RTFC_RXCFG_ADDR: begin
          if (wv[`RTFC_RX_ALIGN_HI:`RTFC_RX_ALIGN_LO] != `RTFC_ALIGN_RSVD) begin
            s_d.align = wv[`RTFC_RX_ALIGN_HI:`RTFC_RX_ALIGN_LO];
          end
          s_d.offset = wv[`RTFC_RX_OFF_HI:`RTFC_RX_OFF_LO];
          s_d.rx_clr = s_q.w_strb[1] && wv[`RTFC_RX_DISCARD_BIT];
        end
        `RTFC_TXCFG_ADDR: begin
          s_d.permit  = wv[`RTFC_TX_PERMIT_BIT];
          s_d.txs_clr = s_q.w_strb[1] && wv[`RTFC_TXS_DISCARD_BIT];
          s_d.txd_clr = s_q.w_strb[1] && wv[`RTFC_TXD_DISCARD_BIT];
        end
        `RTFC_STAT_ADDR: begin
        end
        default: begin
          s_d.bresp = `RTFC_RESP_SLVERR;
        end
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = `RTFC_RESP_OKAY;
      case (s_axi_araddr)
        `RTFC_RXCFG_ADDR: s_d.rdata = rx_word;
        `RTFC_TXCFG_ADDR: s_d.rdata = tx_word;
        `RTFC_STAT_ADDR:  s_d.rdata = st_word;
        default: begin
          s_d.rdata = `RTFC_ZERO32;
          s_d.rresp = `RTFC_RESP_SLVERR;
        end
      endcase
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    s_d.off_out   = off_live;
    s_d.fill_out  = fill_cnt;
    s_d.start_out = tx_start;
    s_d.run_out   = tx_active;
    s_d.full_out  = tx_status_full;
    if (!aresetn) begin
      s_d        = '0;
      s_d.align  = `RTFC_ALIGN_RST;
      s_d.offset = `RTFC_OFF_RST;
    end
    // Ready flops track the free holding slots of the next cycle
    s_d.aw_rdy = !s_d.aw_full;
    s_d.w_rdy  = !s_d.w_full;
    s_d.ar_rdy = !s_d.rvalid;
  end

  always_ff @(posedge aclk) begin
    s_q <= s_d;
  end

  // Ready stays high while a slot is free, so a held request is always taken
  assign s_axi_awready        = s_q.aw_rdy;
  assign s_axi_wready         = s_q.w_rdy;
  assign s_axi_bvalid         = s_q.bvalid;
  assign s_axi_bresp          = s_q.bresp;
  assign s_axi_arready        = s_q.ar_rdy;
  assign s_axi_rvalid         = s_q.rvalid;
  assign s_axi_rdata          = s_q.rdata;
  assign s_axi_rresp          = s_q.rresp;
  assign rx_fifo_ptr_clear    = s_q.rx_clr;
  assign tx_status_ptr_clear  = s_q.txs_clr;
  assign tx_data_ptr_clear    = s_q.txd_clr;
  assign rx_start_byte_offset = s_q.off_out;
  assign rx_fill_dwords       = s_q.fill_out;
  assign tx_frame_start       = s_q.start_out;
  assign tx_running           = s_q.run_out;
  assign tx_status_full_flag  = s_q.full_out;

  // ============================================================
  // Submodules
  rtfc_tx_ctrl u_tx (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .enable_set     (en_set),
    .enable_clr     (en_clr),
    .stop_req       (stop_wr),
    .overrun_permit (s_q.permit),
    .status_full    (tx_status_full),
    .frame_avail    (tx_frame_avail),
    .frame_done     (tx_frame_done),
    .enable         (tx_en),
    .stopping       (tx_stopping),
    .frame_start    (tx_start),
    .active         (tx_active),
    .suspended      (tx_susp)
  );

  rtfc_rx_align u_rx (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .offset_reg  (s_q.offset),
    .align_reg   (s_q.align),
    .dword_read  (rx_dword_read),
    .dword_pos   (rx_dword_pos),
    .last_dword  (rx_last_dword),
    .offset_live (off_live),
    .fill_count  (fill_cnt),
    .align_bad   ()
  );

  // ============================================================
  // Checks
  a_rx_discard: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && s_q.aw_addr == `RTFC_RXCFG_ADDR && s_q.w_strb[1] && s_q.w_data[`RTFC_RX_DISCARD_BIT])
    |=> rx_fifo_ptr_clear ##1 !rx_fifo_ptr_clear)
    else $error("receive discard pulse wrong");
  a_txs_discard: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_status_ptr_clear |-> $past(wr_go) && $past(s_q.aw_addr) == `RTFC_TXCFG_ADDR)
    else $error("status discard without write");
  a_txd_discard: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && s_q.aw_addr == `RTFC_TXCFG_ADDR && s_q.w_strb[1] && s_q.w_data[`RTFC_TXD_DISCARD_BIT])
    |=> tx_data_ptr_clear)
    else $error("data discard missing");
  a_full_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_status_full |=> tx_status_full_flag)
    else $error("full flag not raised");
  a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[`RTFC_RX_DISCARD_BIT] == 1'b0 && s_axi_rdata[7:3] == 5'h00)
    else $error("reserved bits read nonzero");
  a_rx_offset: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 rx_start_byte_offset[1:0] == $past(s_q.offset[1:0]))
    else $error("offset byte bits not applied");
  a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go |=> s_axi_bvalid)
    else $error("write response missing");
  a_enable_run: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_start |-> tx_en)
    else $error("frame started while disabled");
  c_rx_discard: cover property (@(posedge aclk) disable iff (!aresetn) rx_fifo_ptr_clear);
  c_tx_discard: cover property (@(posedge aclk) disable iff (!aresetn) tx_status_ptr_clear && tx_data_ptr_clear);
  c_run: cover property (@(posedge aclk) disable iff (!aresetn) tx_frame_start);
endmodule

// ### tb/rtfc_top_tb.sv
// Self-checking bench for the FIFO control register bank
`timescale 1ns/1ps
`include "rtfc_cfg.svh"
module rtfc_top_tb;
  import rtfc_pkg::*;

  logic        aclk, aresetn;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        rx_dword_read, rx_last_dword, tx_status_full, tx_frame_avail, tx_frame_done;
  logic [2:0]  rx_dword_pos, rx_fill_dwords;
  logic        rx_clr, txs_clr, txd_clr, tx_frame_start, tx_running, tx_full_flag;
  logic [4:0]  rx_start_byte_offset;
  int          mismatches, checks, n_rx, n_txs, n_txd, n_fs;

  rtfc_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_dword_read(rx_dword_read),
    .rx_dword_pos(rx_dword_pos), .rx_last_dword(rx_last_dword), .tx_status_full(tx_status_full),
    .tx_frame_avail(tx_frame_avail), .tx_frame_done(tx_frame_done), .rx_fifo_ptr_clear(rx_clr),
    .tx_status_ptr_clear(txs_clr), .tx_data_ptr_clear(txd_clr),
    .rx_start_byte_offset(rx_start_byte_offset), .rx_fill_dwords(rx_fill_dwords),
    .tx_frame_start(tx_frame_start), .tx_running(tx_running), .tx_status_full_flag(tx_full_flag));

  // ============================================================
  // Clock and pulse counters
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // Pulses last one cycle, so count them instead of polling
  always @(posedge aclk) begin
    if (rx_clr === 1'b1) n_rx <= n_rx + 1;
    if (txs_clr === 1'b1) n_txs <= n_txs + 1;
    if (txd_clr === 1'b1) n_txd <= n_txd + 1;
    if (tx_frame_start === 1'b1) n_fs <= n_fs + 1;
  end

  // ============================================================
  // Shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50) chk(32'h1, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 50) chk(32'h1, 32'h0);
  endtask

  // One host DWORD read on the receive side
  task automatic rx_beat(input logic [2:0] pos, input logic last);
    @(posedge aclk);
    rx_dword_read <= 1'b1;
    rx_dword_pos  <= pos;
    rx_last_dword <= last;
    @(posedge aclk);
    rx_dword_read <= 1'b0;
    rx_last_dword <= 1'b0;
    #1;
  endtask

  // ============================================================
  // Scenarios
  task automatic test_reset_and_decode();
    logic [31:0] d;
    logic [1:0]  r;
    rd(`RTFC_RXCFG_ADDR, d, r);
    chk(d, 32'h0);
    rd(`RTFC_TXCFG_ADDR, d, r);
    chk(d, 32'h0);
    rd(8'h10, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, `RTFC_RESP_SLVERR});
    wr(8'h10, 32'hFFFF_FFFF, r);
    chk({30'h0, r}, {30'h0, `RTFC_RESP_SLVERR});
  endtask

  task automatic test_rx_config();
    logic [31:0] d;
    logic [1:0]  r;
    int c;
    c = n_rx;
    wr(`RTFC_RXCFG_ADDR, 32'hBFFF_FFFF, r);
    repeat (2) @(posedge aclk);
    chk(n_rx - c, 1);
    rd(`RTFC_RXCFG_ADDR, d, r);
    chk(d, 32'h8000_1F00);
    #1 chk({27'h0, rx_start_byte_offset}, 32'h3);
    rx_beat(3'h0, 1'b0);
    @(posedge aclk);
    #1 chk({27'h0, rx_start_byte_offset}, 32'h1F);
    // Reserved code must leave the previous alignment in place
    wr(`RTFC_RXCFG_ADDR, 32'hC000_0000, r);
    rd(`RTFC_RXCFG_ADDR, d, r);
    chk(d, 32'h8000_0000);
  endtask

  task automatic test_rx_fill();
    logic [1:0]  r;
    logic [2:0]  exp [3] = '{3'h0, 3'h1, 3'h5};
    for (int i = 0; i < 3; i++) begin
      wr(`RTFC_RXCFG_ADDR, {i[1:0], 30'h0}, r);
      rx_beat(3'h2, 1'b1);
      chk({29'h0, rx_fill_dwords}, {29'h0, exp[i]});
    end
  endtask

  task automatic test_tx_discards();
    logic [31:0] d;
    logic [1:0]  r;
    int s, t;
    s = n_txs; t = n_txd;
    wr(`RTFC_TXCFG_ADDR, 32'hFFFF_FFFC, r);
    repeat (2) @(posedge aclk);
    chk(n_txs - s, 1);
    chk(n_txd - t, 1);
    rd(`RTFC_TXCFG_ADDR, d, r);
    chk(d, 32'h4);
    wr(`RTFC_TXCFG_ADDR, 32'h0, r);
  endtask

  task automatic test_tx_flow();
    logic [31:0] d;
    logic [1:0]  r;
    int f, n;
    @(posedge aclk);
    tx_status_full <= 1'b1;
    tx_frame_avail <= 1'b1;
    f = n_fs;
    wr(`RTFC_TXCFG_ADDR, 32'h2, r);
    repeat (10) @(posedge aclk);
    chk(n_fs - f, 0);
    chk({31'h0, tx_full_flag}, 32'h1);
    wr(`RTFC_TXCFG_ADDR, 32'h6, r);
    for (n = 0; n < 20 && n_fs == f; n++) @(posedge aclk);
    chk(n_fs - f, 1);
    #1 chk({31'h0, tx_running}, 32'h1);
    chk({31'h0, tx_full_flag}, 32'h1);
    wr(`RTFC_TXCFG_ADDR, 32'h7, r);
    rd(`RTFC_TXCFG_ADDR, d, r);
    chk(d, 32'h7);
    wr(`RTFC_TXCFG_ADDR, 32'h6, r);
    rd(`RTFC_TXCFG_ADDR, d, r);
    chk(d, 32'h7);
    @(posedge aclk) tx_frame_done <= 1'b1;
    @(posedge aclk) tx_frame_done <= 1'b0;
    f = n_fs;
    repeat (10) @(posedge aclk);
    rd(`RTFC_TXCFG_ADDR, d, r);
    chk(d, 32'h4);
    chk(n_fs - f, 0);
    #1 chk({31'h0, tx_running}, 32'h0);
    @(posedge aclk);
    tx_status_full <= 1'b0;
    tx_frame_avail <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({31'h0, tx_full_flag}, 32'h0);
  endtask

  // ============================================================
  // Verdict and main sequence
  task automatic finish_test();
    $display("Checks: %0d, mismatches: %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    // Whole sequence takes well under a thousand cycles
    repeat (5000) @(posedge aclk);
    mismatches++;
    finish_test();
  end

  initial begin
    mismatches = 0; checks = 0; n_rx = 0; n_txs = 0; n_txd = 0; n_fs = 0;
    aresetn = 1'b0; awaddr = 8'h00; araddr = 8'h00; awvalid = 1'b0; wvalid = 1'b0;
    bready = 1'b0; arvalid = 1'b0; rready = 1'b0; wdata = 32'h0; wstrb = 4'hF;
    rx_dword_read = 1'b0; rx_dword_pos = 3'h0; rx_last_dword = 1'b0;
    tx_status_full = 1'b0; tx_frame_avail = 1'b0; tx_frame_done = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    test_reset_and_decode();
    test_rx_config();
    test_rx_fill();
    test_tx_discards();
    test_tx_flow();
    finish_test();
  end
endmodule
